// File: hdl/hbcs_regs.sv
// Bridge command/status register bank with Avalon-MM slave
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Command bit 9 (fast back-to-back enable) always reads zero.
// [R2] Command bit 8 enables system-error messages; zero blocks every message (here only new requests; one already pending is still sent).
// [R3] Messages go over the hub link only for conditions enabled individually.
// [R4] This enable governs only this function; the other function has its own.
// [R5] Command bit 2 (bus master enable) always reads one.
// [R6] Command bit 1 (memory access enable) always reads one.
// [R7] Command bits 7,6,5,4,3,0 are read-only zero.
// [R8] Status bit 14 sets whenever a system-error message was sent.
// [R9] Status bits 14,13,12 clear on written one; zero leaves them.
// [R10] Status bit 13 sets on a master-abort completion or special cycle.
// [R11] Status bit 12 sets on a target-abort completion or special cycle.
// [R12] Status bit 11 reads zero; no target abort is ever issued.
// [R13] Status bits 10:9 select timing always read 00.
// [R14] Status bit 8 parity error detected always reads zero.
// [R15] Status bits 7 and 4 read one; capability pointer sits at 34h.
// [R16] Reserved bits read zero; writes to them and hardwired bits ignored.
// [R17] Reset gives command 0006h and status 0090h, enable and flags clear.
module hbcs_regs (
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  input  wire logic [7:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  output logic      [1:0]                   avs_response,
  input  wire logic [hbcs_pkg::ERR_COND_W-1:0] err_cond,
  input  wire logic                         master_abort_rcvd,
  input  wire logic                         target_abort_rcvd,
  input  wire logic                         syserr_msg_ack,
  output logic                              syserr_msg_req,
  output logic                              irq
);
  import hbcs_pkg::*;

  logic                  syserr_msg_enable;
  logic                  syserr_sent_flag;
  logic                  master_abort_rcvd_flag;
  logic                  target_abort_rcvd_flag;
  logic [ERR_COND_W-1:0] error_command_reg;
  logic [IRQ_W-1:0]      irq_mask;
  logic                  acc_done;
  logic                  wr_go;
  logic                  rd_go;
  logic [15:0]           bridge_command;
  logic [15:0]           bridge_status;
  logic [IRQ_W-1:0]      irq_stat;
  logic                  cond_hit;
  logic                  msg_sent;

  // ----------------------------------------
  // Bus handshake: one wait cycle per access
  // ----------------------------------------
  assign wr_go = avs_write & acc_done;
  assign rd_go = avs_read & acc_done;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= (avs_read | avs_write) & ~acc_done;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & ~acc_done);
    end
  end

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  always_comb begin
    bridge_command = CMD_FIXED; // [R1] [R5] [R6] [R7] [R16]
    bridge_command[CMD_SYSERR_MSG_ENABLE_BIT] = syserr_msg_enable;
    bridge_status = STS_FIXED; // [R12] [R13] [R14] [R15] [R16]
    bridge_status[STS_SSE_BIT]  = syserr_sent_flag;
    bridge_status[STS_MASTER_ABORT_RCVD_FLAG_BIT] = master_abort_rcvd_flag;
    bridge_status[STS_TARGET_ABORT_RCVD_FLAG_BIT] = target_abort_rcvd_flag;
  end

  assign irq_stat = {syserr_sent_flag, master_abort_rcvd_flag,
                     target_abort_rcvd_flag};

  // ----------------------------------------
  // Writable control
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syserr_msg_enable <= CMD_RESET[CMD_SYSERR_MSG_ENABLE_BIT]; // [R17]
    end else if (wr_go && avs_address == OFF_CMD_STS &&
                 avs_byteenable[1]) begin
      syserr_msg_enable <= avs_writedata[CMD_SYSERR_MSG_ENABLE_BIT]; // [R2] [R4]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      error_command_reg <= '0;
    end else if (wr_go && avs_address == OFF_ERROR_COMMAND_REG &&
                 avs_byteenable[0]) begin
      error_command_reg <= avs_writedata[ERR_COND_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= '0;
    end else if (wr_go && avs_address == OFF_IRQ_MASK &&
                 avs_byteenable[0]) begin
      irq_mask <= avs_writedata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // System-error message request
  // ----------------------------------------
  assign cond_hit = syserr_msg_enable & |(err_cond & error_command_reg); // [R3]
  assign msg_sent = syserr_msg_req & syserr_msg_ack;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syserr_msg_req <= 1'b0;
    end else if (msg_sent) begin
      syserr_msg_req <= 1'b0;
    end else if (cond_hit) begin
      syserr_msg_req <= 1'b1; // [R2] [R3]
    end
  end

  // ----------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------
  logic clr_hi;
  logic clr_lo;
  logic [15:0] sts_wd;
  assign sts_wd = avs_writedata[STS_HALF_LSB +: 16];
  assign clr_hi = wr_go && avs_address == OFF_CMD_STS && avs_byteenable[3];
  assign clr_lo = wr_go && avs_address == OFF_IRQ_STAT && avs_byteenable[0];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syserr_sent_flag <= 1'b0; // [R17]
    end else if (msg_sent) begin
      syserr_sent_flag <= 1'b1; // [R8]
    end else if ((clr_hi && sts_wd[STS_SSE_BIT]) ||
                 (clr_lo && avs_writedata[2])) begin
      syserr_sent_flag <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      master_abort_rcvd_flag <= 1'b0;
    end else if (master_abort_rcvd) begin
      master_abort_rcvd_flag <= 1'b1; // [R10]
    end else if ((clr_hi && sts_wd[STS_MASTER_ABORT_RCVD_FLAG_BIT]) ||
                 (clr_lo && avs_writedata[1])) begin
      master_abort_rcvd_flag <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      target_abort_rcvd_flag <= 1'b0;
    end else if (target_abort_rcvd) begin
      target_abort_rcvd_flag <= 1'b1; // [R11]
    end else if ((clr_hi && sts_wd[STS_TARGET_ABORT_RCVD_FLAG_BIT]) ||
                 (clr_lo && avs_writedata[0])) begin
      target_abort_rcvd_flag <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // Read data and response
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
    end else if ((avs_read | avs_write) & ~acc_done) begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
      unique case (avs_address)
        OFF_CMD_STS:  avs_readdata <= {bridge_status, bridge_command};
        OFF_ERROR_COMMAND_REG:   avs_readdata <= {28'h0000000, error_command_reg};
        OFF_IRQ_STAT: avs_readdata <= {29'h00000000, irq_stat};
        OFF_IRQ_MASK: avs_readdata <= {29'h00000000, irq_mask};
        OFF_CAPABILITY_POINTER:   avs_readdata <= {24'h000000, CAPABILITY_POINTER_VALUE};
        default:      avs_response <= 2'h3;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_cmd_fixed_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_go && avs_address == OFF_CMD_STS |->
    avs_readdata[9] == 1'b0 && avs_readdata[2:1] == 2'h3) // [R1]
    else $error("command fixed bits wrong");
  a_msg_gated_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
    !syserr_msg_enable && !syserr_msg_req |=> !syserr_msg_req) // [R2]
    else $error("message without enable");
  a_msg_on_cond: assert property (@(posedge ref_clk) disable iff (!resetn)
    cond_hit && !syserr_msg_req |=> syserr_msg_req) // [R3]
    else $error("enabled condition not messaged");
  a_enable_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_go && avs_address == OFF_CMD_STS && avs_byteenable[1] |=>
    syserr_msg_enable == $past(avs_writedata[8])) // [R4]
    else $error("enable not written");
  a_cmd_zero_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_go && avs_address == OFF_CMD_STS |->
    avs_readdata[15:10] == 6'h00 && avs_readdata[7:3] == 5'h00 &&
    !avs_readdata[0]) // [R7]
    else $error("command zero bits wrong");
  a_sse_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
    msg_sent |=> syserr_sent_flag) // [R8]
    else $error("sent flag not set");
  a_w1c_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    clr_hi && sts_wd[13] && !master_abort_rcvd |=> !master_abort_rcvd_flag)
    // [R9]
    else $error("flag not cleared");
  a_w0_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
    clr_hi && !sts_wd[12] && target_abort_rcvd_flag |=>
    target_abort_rcvd_flag) // [R9]
    else $error("zero write cleared flag");
  a_master_abort_rcvd_flag_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
    master_abort_rcvd |=> master_abort_rcvd_flag) // [R10]
    else $error("master abort not flagged");
  a_target_abort_rcvd_flag_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
    target_abort_rcvd |=> target_abort_rcvd_flag) // [R11]
    else $error("target abort not flagged");
  a_sts_fixed_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_go && avs_address == OFF_CMD_STS |->
    avs_readdata[27:24] == 4'h0 && avs_readdata[23] && avs_readdata[20] &&
    avs_readdata[31] == 1'b0 && avs_readdata[22:21] == 2'h0 &&
    avs_readdata[19:16] == 4'h0) // [R12]
    else $error("status fixed bits wrong");
  a_wait_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(avs_read) ##0 !acc_done |=> !avs_waitrequest)
    else $error("answer late");

  c_msg_sent: cover property (@(posedge ref_clk) disable iff (!resetn)
    msg_sent);
  c_set_clear: cover property (@(posedge ref_clk) disable iff (!resetn)
    master_abort_rcvd && clr_hi && sts_wd[13]);
  c_irq: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(irq));
endmodule // hbcs_regs

// File: hdl/hbcs_pkg.sv
// Constants for the bridge command and status register bank
package hbcs_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0]  OFF_CMD_STS   = 8'h04;
  localparam logic [7:0]  OFF_ERROR_COMMAND_REG    = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h18;
  localparam logic [7:0]  OFF_CAPABILITY_POINTER    = 8'h34;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CMD_SYSERR_MSG_ENABLE_BIT = 8;
  localparam int STS_SSE_BIT   = 14;
  localparam int STS_MASTER_ABORT_RCVD_FLAG_BIT  = 13;
  localparam int STS_TARGET_ABORT_RCVD_FLAG_BIT  = 12;
  localparam int STS_HALF_LSB  = 16;
  localparam int ERR_COND_W    = 4;
  localparam int IRQ_W         = 3;
  // ----------------------------------------
  // Fixed values and resets
  // ----------------------------------------
  localparam logic [15:0] CMD_FIXED     = 16'h0006;
  localparam logic [15:0] STS_FIXED     = 16'h0090;
  localparam logic [15:0] CMD_RESET     = 16'h0006;
  localparam logic [15:0] STS_RESET     = 16'h0090;
  localparam logic [7:0]  CAPABILITY_POINTER_VALUE  = 8'ha0;
endpackage

// File: sim/hbcs_hub_model.sv
// Hub link partner: accepts messages, returns abort completions
`timescale 1ns/10ps
module hbcs_hub_model (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       syserr_msg_req,
  input  wire logic [3:0] ack_delay,
  input  wire logic       ma_go,
  input  wire logic       ta_go,
  output logic            syserr_msg_ack,
  output logic            master_abort_rcvd,
  output logic            target_abort_rcvd
);
  logic [3:0] cnt;
  logic       take;
  assign take = syserr_msg_req && !syserr_msg_ack && cnt == ack_delay;
  // Message accepted after ack_delay cycles
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt            <= 4'h0;
      syserr_msg_ack <= 1'h0;
    end else begin
      syserr_msg_ack <= take;
      cnt <= (syserr_msg_req && !take) ? cnt + 4'h1 : 4'h0;
    end
  end
  // One-cycle abort completions on command
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      master_abort_rcvd <= 1'h0;
      target_abort_rcvd <= 1'h0;
    end else begin
      master_abort_rcvd <= ma_go;
      target_abort_rcvd <= ta_go;
    end
  end
endmodule // hbcs_hub_model

// File: sim/hbcs_regs_bench.sv
// Self-checking bench for the bridge command/status registers
`timescale 1ns/10ps
module hbcs_regs_bench;
  import hbcs_pkg::*;
  logic        ref_clk = 1'h0;
  logic        resetn = 1'h0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [3:0]  err_cond = 4'h0;
  logic [3:0]  ack_delay = 4'h0;
  logic        ma_go = 1'h0;
  logic        ta_go = 1'h0;
  logic [31:0] avs_readdata, rd;
  logic [1:0]  avs_response, rsp;
  logic        avs_waitrequest, syserr_msg_req, syserr_msg_ack, irq;
  logic        master_abort_rcvd, target_abort_rcvd;
  int          errors = 0;
  int          num_checks = 0;

  always #25 ref_clk = ~ref_clk;
  hbcs_regs      uut (.*);
  hbcs_hub_model hub (.*);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest sampled at the rising edge; data taken at that edge
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) begin
        errors++;
        $display("[ERR] %0t bus timeout", $time);
        wrap_up();
      end
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic pulse(input logic master);
    @(posedge ref_clk);
    ma_go <= master;
    ta_go <= !master;
    @(posedge ref_clk);
    ma_go <= 1'h0;
    ta_go <= 1'h0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic wait_req(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && syserr_msg_req !== lvl; n++)
      @(negedge ref_clk);
    if (lim > 12) begin
      chk({31'h0, syserr_msg_req}, {31'h0, lvl}, "msg req");
      if (syserr_msg_req !== lvl) wrap_up();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({31'h0, irq}, 32'h0, "irq at reset");
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h0090_0006, "reset value");
    chk({30'h0, rsp}, 32'h0, "response ok");
    bus(1'h0, OFF_CAPABILITY_POINTER, 32'h0, 4'hf);
    chk(rd & 32'hff, 32'ha0, "cap pointer");
  endtask
  task automatic t_cmd;
    bus(1'h1, OFF_CMD_STS, 32'hffff_ffff, 4'hf);
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h0090_0106, "ones written");
    bus(1'h1, OFF_CMD_STS, 32'h0, 4'h2);
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h0090_0006, "enable off");
  endtask
  task automatic t_abort;
    pulse(1'h1);
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h2090_0006, "master abort");
    pulse(1'h0);
    bus(1'h1, OFF_CMD_STS, 32'h0, 4'hf);
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h3090_0006, "zero write");
    bus(1'h1, OFF_CMD_STS, 32'h2000_0000, 4'h8);
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h1090_0006, "clear bit13");
  endtask
  task automatic t_irq;
    bus(1'h1, OFF_IRQ_MASK, 32'h6, 4'hf);
    pulse(1'h0);
    chk({31'h0, irq}, 32'h0, "masked irq");
    bus(1'h0, OFF_IRQ_STAT, 32'h0, 4'hf);
    chk(rd & 32'h7, 32'h1, "irq status");
    bus(1'h1, OFF_IRQ_MASK, 32'h7, 4'hf);
    repeat (2) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    bus(1'h1, OFF_IRQ_STAT, 32'h1, 4'hf);
    repeat (2) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h0090_0006, "alias clear");
  endtask
  task automatic t_serr(input logic [3:0] dly);
    bus(1'h1, OFF_CMD_STS, 32'h0, 4'h2);
    bus(1'h1, OFF_ERROR_COMMAND_REG, 32'hf, 4'hf);
    err_cond <= 4'h1;
    wait_req(1'h1, 10);
    chk({31'h0, syserr_msg_req}, 32'h0, "no msg off");
    bus(1'h1, OFF_ERROR_COMMAND_REG, 32'he, 4'hf);
    bus(1'h1, OFF_CMD_STS, 32'h100, 4'h2);
    wait_req(1'h1, 10);
    chk({31'h0, syserr_msg_req}, 32'h0, "no msg cond off");
    ack_delay <= dly;
    bus(1'h1, OFF_ERROR_COMMAND_REG, 32'h1, 4'hf);
    wait_req(1'h1, 20);
    err_cond <= 4'h0;
    wait_req(1'h0, 40);
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h4090_0106, "msg sent flag");
    bus(1'h1, OFF_CMD_STS, 32'h4000_0000, 4'h8);
    bus(1'h0, OFF_CMD_STS, 32'h0, 4'hf);
    chk(rd, 32'h0090_0106, "clear bit14");
  endtask
  task automatic t_unmap;
    bus(1'h1, 8'h20, 32'hffff_ffff, 4'hf);
    bus(1'h0, 8'h20, 32'h0, 4'hf);
    chk(rd, 32'h0, "unmapped data");
    chk({30'h0, rsp}, 32'h3, "unmapped response");
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'h1;
    t_reset();
    t_cmd();
    t_abort();
    t_irq();
    t_serr(4'h0);
    t_serr(4'h5);
    t_unmap();
    wrap_up();
  end
endmodule // hbcs_regs_bench
